// >>> src/aid_core.sv
// alu and bit-manipulation instruction decoder/executor with avalon-mm access
`timescale 1ns/1ps
// Function
// - instruction rate is clock divided by one (fast) or four (slow)
// - in fast mode branches take three clocks, program-memory read takes four
// - fast/slow choice comes from the fuse word input, not a register
// - file AND accumulator into file, zero flag only
// - accumulator AND file into accumulator, zero flag only
// - literal AND, OR, XOR into accumulator updating zero
// - ones complement of file register, updates zero
// - accumulator OR into file register, updates zero
// - file OR accumulator into accumulator, updates zero
// - XOR accumulator with file into file or accumulator, updates zero
// - add with optional carry in, updates carry, digit carry, zero
// - file minus accumulator into file, optional borrow, updates C DC Z
// - watchdog clear resets counter, and prescaler only when PRESCALE_TO_WDT is set, sets timeout and power-down
// - decrement or increment file register, zero flag only
// - decrement/increment and skip if zero, flags unchanged
// - skip instructions take one/four clocks, or two/eight when skipping
// - rotate file left or right through carry, carry only
// - swap nibbles of file register, no flags
// - clear or set selected bit, no flags
// - skip next if selected bit one or zero, no flags
// - status holds C bit0, DC bit1, Z bit2, PD bit3, TO bit4
// - taken skip also skips following page/bank instructions, one/four clocks each
module aid_core #(
	parameter int NFILE = 32
) (
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        FUSE_SLOW,
	input  wire logic        FUSE_CARRY_DIS,
	input  wire logic        PRESCALE_TO_WDT,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             WDT_CLEAR,
	output logic             PRESCALE_CLEAR,
	output logic             BUSY
);
	// file register array; address 3 mirrors the status register
	logic [7:0]  file_r [NFILE];
	logic [7:0]  acc_r;
	logic [7:0]  status_r;
	logic [11:0] op_r;
	logic        pend_r;
	logic        skipping_r;
	logic [3:0]  cnt_r;
	logic        ack_r;
	logic [31:0] rdata_r;
	logic        wdt_r;
	logic        pre_r;

	wire [4:0] fsel  = op_r[4:0];
	wire [2:0] bsel  = op_r[7:5];
	wire [7:0] lit   = op_r[7:0];
	wire [7:0] fval  = (fsel == 5'd3) ? status_r : file_r[fsel];
	wire       cin   = status_r[aid_pkg::ST_C];
	wire       cadd  = ~FUSE_CARRY_DIS & cin;
	wire [8:0] sum   = {1'b0, acc_r} + {1'b0, fval} + {8'h00, cadd};
	wire [4:0] lsum  = {1'b0, acc_r[3:0]} + {1'b0, fval[3:0]} + {4'h0, cadd};
	// subtract as fval + ~acc + carry, carry meaning no borrow
	wire       csub  = FUSE_CARRY_DIS ? 1'b1 : cin;
	wire [8:0] dif   = {1'b0, fval} + {1'b0, ~acc_r} + {8'h00, csub};
	wire [4:0] ldif  = {1'b0, fval[3:0]} + {1'b0, ~acc_r[3:0]} + {4'h0, csub};
	wire       page_op = (op_r[11:4] == 8'h01) | (op_r[11:3] == 9'h003);

	aid_pkg::aid_res_type ex;
	aid_pkg::aid_kind_type kind;

	always_comb begin
		ex = '0;
		kind = aid_pkg::K_PLAIN;
		ex.c = cin;
		ex.dc = status_r[aid_pkg::ST_DC];
		unique casez (op_r)
			12'b0001_011?_????: begin ex.res = fval & acc_r; ex.wr_f = 1'b1; ex.upd_z = 1'b1; end
			12'b0001_010?_????: begin ex.res = acc_r & fval; ex.wr_w = 1'b1; ex.upd_z = 1'b1; end
			12'b1110_????_????: begin ex.res = acc_r & lit; ex.wr_w = 1'b1; ex.upd_z = 1'b1; end
			12'b1101_????_????: begin ex.res = acc_r | lit; ex.wr_w = 1'b1; ex.upd_z = 1'b1; end
			12'b1111_????_????: begin ex.res = acc_r ^ lit; ex.wr_w = 1'b1; ex.upd_z = 1'b1; end
			12'b0010_011?_????: begin ex.res = fval ^ 8'hFF; ex.wr_f = 1'b1; ex.upd_z = 1'b1; end
			12'b0001_001?_????: begin ex.res = fval | acc_r; ex.wr_f = 1'b1; ex.upd_z = 1'b1; end
			12'b0001_000?_????: begin ex.res = acc_r | fval; ex.wr_w = 1'b1; ex.upd_z = 1'b1; end
			12'b0001_101?_????: begin ex.res = fval ^ acc_r; ex.wr_f = 1'b1; ex.upd_z = 1'b1; end
			12'b0001_100?_????: begin ex.res = fval ^ acc_r; ex.wr_w = 1'b1; ex.upd_z = 1'b1; end
			12'b0001_11??_????: begin
				ex.res = sum[7:0]; ex.c = sum[8]; ex.dc = lsum[4];
				ex.wr_f = op_r[5]; ex.wr_w = ~op_r[5];
				ex.upd_z = 1'b1; ex.upd_c = 1'b1; ex.upd_dc = 1'b1;
			end
			12'b0000_101?_????: begin
				ex.res = dif[7:0]; ex.c = dif[8]; ex.dc = ldif[4];
				ex.wr_f = 1'b1; ex.upd_z = 1'b1; ex.upd_c = 1'b1; ex.upd_dc = 1'b1;
			end
			12'b0000_011?_????: begin ex.res = 8'h00; ex.wr_f = 1'b1; ex.upd_z = 1'b1; end
			aid_pkg::OP_CLRW: begin ex.res = 8'h00; ex.wr_w = 1'b1; ex.upd_z = 1'b1; end
			aid_pkg::OP_CWDT: ex.wdt = 1'b1;
			aid_pkg::OP_PREAD: kind = aid_pkg::K_PREAD;
			12'b0000_111?_????: begin ex.res = fval - 8'h01; ex.wr_f = 1'b1; ex.upd_z = 1'b1; end
			12'b0010_101?_????: begin ex.res = fval + 8'h01; ex.wr_f = 1'b1; ex.upd_z = 1'b1; end
			12'b0010_111?_????: begin
				ex.res = fval - 8'h01; ex.wr_f = 1'b1; ex.skip = (ex.res == 8'h00);
			end
			12'b0011_111?_????: begin
				ex.res = fval + 8'h01; ex.wr_f = 1'b1; ex.skip = (ex.res == 8'h00);
			end
			12'b0011_011?_????: begin
				ex.res = {fval[6:0], cin}; ex.c = fval[7]; ex.wr_f = 1'b1; ex.upd_c = 1'b1;
			end
			12'b0011_001?_????: begin
				ex.res = {cin, fval[7:1]}; ex.c = fval[0]; ex.wr_f = 1'b1; ex.upd_c = 1'b1;
			end
			12'b0011_101?_????: begin ex.res = {fval[3:0], fval[7:4]}; ex.wr_f = 1'b1; end
			12'b010?_????_????: begin
				ex.res = fval;
				ex.res[bsel] = op_r[8];
				ex.wr_f = 1'b1;
			end
			12'b011?_????_????: ex.skip = (fval[bsel] == op_r[8]);
			12'b101?_????_????: kind = aid_pkg::K_BRANCH;
			12'b100?_????_????: kind = aid_pkg::K_BRANCH;
			default: ;
		endcase
		if (page_op)
			kind = aid_pkg::K_PAGE;
	end

	// clocks per instruction; skip doubles it
	wire [3:0] base_clks = FUSE_SLOW ? 4'(aid_pkg::SLOW_DIV) :
		(kind == aid_pkg::K_BRANCH) ? 4'(aid_pkg::BRANCH_CLKS) :
		(kind == aid_pkg::K_PREAD)  ? 4'(aid_pkg::PREAD_CLKS) : 4'h1;
	wire [3:0] skip_clks = FUSE_SLOW ? 4'(aid_pkg::SLOW_DIV) : 4'h1;
	wire       last      = pend_r & (cnt_r == 4'h1);
	// a skipped page/bank op keeps skipping alive for the next one
	wire       squash    = skipping_r;
	wire       execute   = last & ~squash;
	wire       take_skip = execute & ex.skip;
	wire       keep_skip = last & squash & page_op;
	wire       zero      = (ex.res == 8'h00);

	wire       bus_req  = (AVS_READ | AVS_WRITE) & ~ack_r;
	// a write lands at the edge after waitrequest drops, never while it still stands
	wire       bus_wr   = ack_r & AVS_WRITE & ~pend_r;
	wire [4:0] bus_idx  = AVS_WRITEDATA[12:8];
	wire       idx_st   = (bus_idx == 5'h03);
	wire       wr_instr = bus_wr & (AVS_ADDRESS == aid_pkg::A_INSTR);
	wire       wr_acc   = bus_wr & (AVS_ADDRESS == aid_pkg::A_ACC);
	wire       wr_stat  = bus_wr & ((AVS_ADDRESS == aid_pkg::A_STATUS) |
		((AVS_ADDRESS == aid_pkg::A_FILE) & idx_st));
	wire       wr_file  = bus_wr & (AVS_ADDRESS == aid_pkg::A_FILE) & ~idx_st;
	wire [7:0] bus_fval = idx_st ? status_r : file_r[bus_idx];
	// writes wait while an instruction runs so state never has two writers
	wire       bus_ok   = bus_req & (AVS_READ | ~pend_r);
	wire [31:0] rsel =
		(AVS_ADDRESS == aid_pkg::A_INSTR)  ? {19'h0, pend_r, op_r} :
		(AVS_ADDRESS == aid_pkg::A_ACC)    ? {24'h0, acc_r} :
		(AVS_ADDRESS == aid_pkg::A_STATUS) ? {24'h0, status_r} :
		(AVS_ADDRESS == aid_pkg::A_FILE)   ? {16'h0, bus_fval, 8'h00} :
		32'h0;

	logic [7:0] status_nxt;
	always_comb begin
		status_nxt = status_r;
		if (execute) begin
			if (ex.upd_c)  status_nxt[aid_pkg::ST_C]  = ex.c;
			if (ex.upd_dc) status_nxt[aid_pkg::ST_DC] = ex.dc;
			if (ex.upd_z)  status_nxt[aid_pkg::ST_Z]  = zero;
			if (ex.wdt) begin
				status_nxt[aid_pkg::ST_TO] = 1'b1;
				status_nxt[aid_pkg::ST_PD] = 1'b1;
			end
			if (ex.wr_f && fsel == 5'd3)
				status_nxt = ex.res;
		end else if (wr_stat) begin
			status_nxt = AVS_WRITEDATA[7:0];
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			acc_r <= aid_pkg::ACC_RST;
			status_r <= aid_pkg::STATUS_RST;
			op_r <= aid_pkg::NOP_OP;
			pend_r <= 1'b0;
			skipping_r <= 1'b0;
			cnt_r <= 4'h0;
		end else begin
			status_r <= status_nxt;
			if (execute && ex.wr_w)
				acc_r <= ex.res;
			else if (wr_acc)
				acc_r <= AVS_WRITEDATA[7:0];
			if (wr_instr) begin
				op_r <= AVS_WRITEDATA[11:0];
				pend_r <= 1'b1;
				cnt_r <= 4'h0;
			end else if (pend_r && cnt_r == 4'h0) begin
				cnt_r <= squash ? skip_clks : base_clks;
			end else if (pend_r) begin
				cnt_r <= cnt_r - 4'h1;
				if (last)
					pend_r <= 1'b0;
			end
			if (last)
				skipping_r <= take_skip | keep_skip;
		end
	end

	always_ff @(posedge CLK) begin
		if (execute && ex.wr_f && fsel != 5'd3)
			file_r[fsel] <= ex.res;
		else if (wr_file)
			file_r[bus_idx] <= AVS_WRITEDATA[7:0];
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0;
			wdt_r <= 1'b0;
			pre_r <= 1'b0;
		end else begin
			ack_r <= bus_ok;
			rdata_r <= rsel;
			wdt_r <= execute & ex.wdt;
			pre_r <= execute & ex.wdt & PRESCALE_TO_WDT;
		end
	end

	assign AVS_WAITREQUEST = ~ack_r;
	assign AVS_READDATA    = rdata_r;
	assign WDT_CLEAR       = wdt_r;
	assign PRESCALE_CLEAR  = pre_r;

	always_ff @(posedge CLK) begin
		BUSY <= pend_r;
	end

	chk_wdt_flags: assert property (@(posedge CLK) disable iff (!RSTN)
		(execute && ex.wdt) |=> (WDT_CLEAR && status_r[4:3] == 2'b11))
		else $error("watchdog clear did not set flags");
	chk_fast_plain: assert property (@(posedge CLK) disable iff (!RSTN)
		(wr_instr && !FUSE_SLOW && !skipping_r && AVS_WRITEDATA[11:10] == 2'h3)
		|=> pend_r [*2] ##1 !pend_r)
		else $error("fast plain op length wrong");
	chk_slow_plain: assert property (@(posedge CLK) disable iff (!RSTN)
		(wr_instr && FUSE_SLOW && !skipping_r && AVS_WRITEDATA[11:0] == aid_pkg::OP_CLRW)
		|=> pend_r [*5] ##1 !pend_r)
		else $error("slow plain op length wrong");
	chk_branch_len: assert property (@(posedge CLK) disable iff (!RSTN)
		(wr_instr && !FUSE_SLOW && !skipping_r && AVS_WRITEDATA[11:10] == 2'h2)
		|=> pend_r [*4] ##1 !pend_r)
		else $error("fast branch length wrong");
	chk_prescale_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
		PRESCALE_CLEAR |-> WDT_CLEAR)
		else $error("prescaler cleared without watchdog clear");
	chk_bit_flags: assert property (@(posedge CLK) disable iff (!RSTN)
		(execute && op_r[11:10] == 2'h1 && fsel != 5'h03) |=> status_r == $past(status_r))
		else $error("bit op touched flags");
	chk_z_flag: assert property (@(posedge CLK) disable iff (!RSTN)
		(execute && ex.upd_z && !(ex.wr_f && fsel == 5'd3)) |=> status_r[2] == $past(zero))
		else $error("zero flag wrong");
	chk_skip_flags: assert property (@(posedge CLK) disable iff (!RSTN)
		(execute && ex.skip && fsel != 5'd3) |=> status_r == $past(status_r))
		else $error("skip changed flags");
	chk_skip_arm: assert property (@(posedge CLK) disable iff (!RSTN)
		take_skip |=> skipping_r)
		else $error("skip not armed");
	chk_squash_noop: assert property (@(posedge CLK) disable iff (!RSTN)
		(last && squash) |=> acc_r == $past(acc_r))
		else $error("skipped op wrote accumulator");
	chk_swap_flags: assert property (@(posedge CLK) disable iff (!RSTN)
		(execute && op_r[11:5] == 7'b0011101 && fsel != 5'd3) |=> status_r == $past(status_r))
		else $error("swap touched flags");
	chk_rot_carry: assert property (@(posedge CLK) disable iff (!RSTN)
		(execute && op_r[11:5] == 7'b0011011 && fsel != 5'd3) |=> status_r[0] == $past(fval[7]))
		else $error("rotate carry wrong");
endmodule

// >>> pkg/aid_pkg.sv
// package: opcode patterns, status bit positions, timing counts and bus map for the alu decoder
package aid_pkg;
	localparam int DW = 8;
	localparam int IW = 12;
	// status bit positions
	localparam int ST_C  = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z  = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	// cycle counts
	localparam int SLOW_DIV    = 4;
	localparam int BRANCH_CLKS = 3;
	localparam int PREAD_CLKS  = 4;
	// register byte addresses on the bus
	localparam logic [3:0] A_INSTR  = 4'h0;
	localparam logic [3:0] A_ACC    = 4'h4;
	localparam logic [3:0] A_STATUS = 4'h8;
	localparam logic [3:0] A_FILE   = 4'hC;
	// reset values
	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [7:0]  STATUS_RST = 8'h18;
	localparam logic [11:0] NOP_OP     = 12'h000;
	// opcode classes
	localparam logic [11:0] OP_CLRW = 12'h040;
	localparam logic [11:0] OP_CWDT = 12'h004;
	localparam logic [11:0] OP_PREAD = 12'h041;
	typedef enum logic [1:0] {K_PLAIN, K_BRANCH, K_PREAD, K_PAGE} aid_kind_type;
	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       dc;
		logic       wr_f;
		logic       wr_w;
		logic       upd_z;
		logic       upd_c;
		logic       upd_dc;
		logic       skip;
		logic       wdt;
	} aid_res_type;
endpackage

// >>> test/aid_bus_master.sv
// avalon-mm master model that owns the decoder's register port
`timescale 1ns/1ps
module aid_bus_master (
	input  wire logic        CLK,
	output logic      [3:0]  AVS_ADDRESS,
	output logic             AVS_READ,
	output logic             AVS_WRITE,
	output logic      [31:0] AVS_WRITEDATA,
	input  wire logic [31:0] AVS_READDATA,
	input  wire logic        AVS_WAITREQUEST
);
	initial begin
		AVS_ADDRESS = 4'h0;
		AVS_READ = 1'h0;
		AVS_WRITE = 1'h0;
		AVS_WRITEDATA = 32'h0;
	end
	// request stands until waitrequest is sampled low; idle lines show inverted junk
	task automatic xfer(input logic is_wr, input logic [3:0] adr, input logic [31:0] dat,
		output logic [31:0] q);
		@(posedge CLK);
		AVS_ADDRESS <= adr;
		AVS_WRITEDATA <= dat;
		AVS_READ <= ~is_wr;
		AVS_WRITE <= is_wr;
		@(posedge CLK);
		while (AVS_WAITREQUEST !== 1'h0)
			@(posedge CLK);
		q = AVS_READDATA;
		AVS_READ <= 1'h0;
		AVS_WRITE <= 1'h0;
		AVS_ADDRESS <= ~adr;
		AVS_WRITEDATA <= ~dat;
	endtask
endmodule

// >>> test/tb_aid_core.sv
// self-checking bench: runs opcodes over the register port and checks results
`timescale 1ns/1ps
`define AID_CHK(nm, ex, got) \
	begin \
		cmp_count++; \
		if ((got) !== (ex)) begin \
			fails++; \
			$display("MISMATCH %s expected %h seen %h", nm, ex, got); \
		end \
	end
module tb_aid_core;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        fuse_slow = 1'h0;
	logic        fuse_cdis = 1'h1;
	logic        pre_wdt = 1'h1;
	logic [3:0]  adr;
	logic        rd;
	logic        wr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        wreq;
	logic        wdt_clr;
	logic        pre_clr;
	logic        busy;
	logic [31:0] q;
	int          fails = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          busy_cnt = 0;
	int          wdt_cnt = 0;
	int          pre_cnt = 0;
	int          t_ref;
	// each row: opcode, then expected accumulator, file 5 and status afterwards
	logic [35:0] tbl [35] = '{
		36'hD5A5AF018, 36'h1655A5018, 36'h145505018,
		36'hF5000501C, 36'h125005018, 36'h26500AF18,
		36'h105AFAF18, 36'h1A5AF001C, 36'h2A5AF0118,
		36'h0E5AF001C, 36'h1E5AFAF18, 36'h1C55EAF1B,
		36'h0A55E511B, 36'h3655EA31A, 36'h3255E511B,
		36'h3A55E151B, 36'h4855E051B, 36'h5E55E851B,
		36'h0655E001F, 36'h04000001F, 36'h2E500FF1F,
		36'h3E500001F, 36'h2A500001F, 36'h2A500011B,
		36'h60500011B, 36'h2A500021B, 36'h60500021B,
		36'h01000021B, 36'h2A500021B, 36'h72500021B,
		36'h2A500021B, 36'h2A500031B, 36'h1C5040318,
		36'h0A504FE18, 36'hE0300FE1C};

	aid_core uut (.CLK(clk), .RSTN(rst_n), .FUSE_SLOW(fuse_slow), .FUSE_CARRY_DIS(fuse_cdis),
		.PRESCALE_TO_WDT(pre_wdt), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
		.WDT_CLEAR(wdt_clr), .PRESCALE_CLEAR(pre_clr), .BUSY(busy));
	aid_bus_master bus (.CLK(clk), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq));

	always #10 clk = ~clk;

	// sampled on the falling edge so the counts never race the bus tasks
	always @(negedge clk) begin
		cycles++;
		if (busy === 1'h1)
			busy_cnt++;
		if (wdt_clr === 1'h1)
			wdt_cnt++;
		if (pre_clr === 1'h1)
			pre_cnt++;
		if (cycles == 20000) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [4:0] idx, output logic [31:0] d);
		bus.xfer(1'h0, a, {19'h0, idx, 8'h00}, d);
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] unused;
		bus.xfer(1'h1, a, d, unused);
	endtask

	task automatic exec(input logic [11:0] op);
		busy_cnt = 0;
		wr_reg(aid_pkg::A_INSTR, {20'h0, op});
		q = 32'h0000_1000;
		while (q[12] !== 1'h0)
			rd_reg(aid_pkg::A_INSTR, 5'h00, q);
	endtask

	task automatic check(input logic [35:0] row);
		exec(row[35:24]);
		rd_reg(aid_pkg::A_ACC, 5'h00, q);
		`AID_CHK("acc", row[23:16], q[7:0])
		rd_reg(aid_pkg::A_FILE, 5'h05, q);
		`AID_CHK("file", row[15:8], q[15:8])
		rd_reg(aid_pkg::A_STATUS, 5'h00, q);
		`AID_CHK("status", row[7:0], q[7:0])
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		rd_reg(aid_pkg::A_STATUS, 5'h00, q);
		`AID_CHK("status reset", 8'h18, q[7:0])
		rd_reg(4'h2, 5'h00, q);
		`AID_CHK("unmapped read", 32'h0, q)
		wr_reg(4'h6, 32'hFFFF_FFFF);
		wr_reg(aid_pkg::A_FILE, 32'h0000_05F0);
		for (int i = 0; i < 35; i++) begin
			if (i == 32)
				fuse_cdis <= 1'h0;
			check(tbl[i]);
		end
		wr_reg(aid_pkg::A_FILE, 32'h0000_0300);
		check({aid_pkg::OP_CWDT, 8'h00, 8'hFE, 8'h18});
		`AID_CHK("wdt pulses", 2'h1, wdt_cnt[1:0])
		`AID_CHK("prescale pulses", 2'h1, pre_cnt[1:0])
		pre_wdt <= 1'h0;
		check({aid_pkg::OP_CWDT, 8'h00, 8'hFE, 8'h18});
		`AID_CHK("wdt pulses", 2'h2, wdt_cnt[1:0])
		`AID_CHK("prescale pulses", 2'h1, pre_cnt[1:0])
		rd_reg(aid_pkg::A_FILE, 5'h03, q);
		`AID_CHK("status as file", 8'h18, q[15:8])
		exec(aid_pkg::OP_CLRW);
		t_ref = busy_cnt;
		exec(12'h800);
		`AID_CHK("branch clocks", t_ref + 2, busy_cnt)
		exec(aid_pkg::OP_PREAD);
		`AID_CHK("read clocks", t_ref + 3, busy_cnt)
		fuse_slow <= 1'h1;
		exec(aid_pkg::OP_CLRW);
		`AID_CHK("slow clocks", t_ref + 3, busy_cnt)
		exec(12'h605);
		t_ref = busy_cnt;
		check({12'h2A5, 8'h00, 8'hFE, 8'h1C});
		`AID_CHK("squash clocks", t_ref, busy_cnt)
		// an accumulator write issued while an op runs must wait for it to finish
		wr_reg(aid_pkg::A_INSTR, {20'h0, aid_pkg::OP_CLRW});
		wr_reg(aid_pkg::A_ACC, 32'h0000_0077);
		rd_reg(aid_pkg::A_ACC, 5'h00, q);
		`AID_CHK("stalled write", 8'h77, q[7:0])
		tally_and_finish();
	end
endmodule
